// *** anadv_pkg.sv ***
// Constants, field layouts and carrier types for the auto-negotiation advertisement register bank.
// Assumes a single 100 MHz clock domain and an AXI4-Lite register master.
// Functional notes
// - New advertisement applies only after negotiation restart.
// - Software may overwrite ability bits eight to five.
// - Ability bits advertise 100TX/10T full/half modes.
// - Selector field reads fixed one, read-only.
// - Advertisement resets with abilities and selector set.
// - Partner abilities captured read-only, reset zero.
package anadv_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [7:0] ANADV_IDX_LOCAL = 8'h04;
  localparam logic [7:0] ANADV_IDX_PARTNER = 8'h05;
  // Own control/status word: bit 0 restart (write one), bit 1 partner page valid.
  localparam logic [7:0] ANADV_IDX_CTRL = 8'h08;
  localparam logic [11:0] ANADV_ADDR_LOCAL = 12'h010;
  localparam logic [11:0] ANADV_ADDR_PARTNER = 12'h014;
  localparam logic [11:0] ANADV_ADDR_CTRL = 12'h020;
  // Reset values.
  localparam logic [15:0] ANADV_LOCAL_RST = 16'h01e1;
  localparam logic [15:0] ANADV_PARTNER_RST = 16'h0000;
  // Field positions.
  localparam int ANADV_RF_BIT = 13;
  localparam int ANADV_NP_BIT = 15;
  localparam int ANADV_RESTART_BIT = 0;
  // Writable mask: remote fault and the four ability bits.
  localparam logic [15:0] ANADV_WR_MASK = 16'h21e0;
  localparam logic [4:0] ANADV_SELECTOR = 5'h01;
  // AXI responses.
  localparam logic [1:0] ANADV_RESP_OKAY = 2'h0;
  localparam logic [1:0] ANADV_RESP_SLVERR = 2'h2;

  // Abilities actually in use by the negotiation logic.
  typedef struct packed {
    logic next_page_flag;
    logic remote_fault_flag;
    logic tx100_full_ability;
    logic tx100_half_ability;
    logic t10_full_ability;
    logic t10_half_ability;
  } anadv_ability_t;
endpackage

// *** anadv_regs.sv ***
// AXI4-Lite register bank holding local advertisement and partner abilities.
// Assumes the negotiation engine supplies a partner page strobe on the same clock.
`timescale 1ns/1ps
module anadv_regs
  import anadv_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clk_en,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic partner_page_valid,
  input wire logic [15:0] partner_page,
  output logic restart_autoneg,
  output anadv_ability_t active_ability
);
  // Software-visible advertisement, captured partner abilities and the partner page seen flag.
  logic [15:0] local_advert_reg_q;
  logic [15:0] partner_ability_reg_q;
  logic partner_seen_q;
  // Write channel capture, either order.
  logic aw_held_q;
  logic w_held_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic do_write;
  logic [15:0] merged;
  // Software view of the advertisement, shared by the checks below.
  logic [15:0] local_rd_view;

  // Read view of the advertisement: selector forced, next page zero.
  function automatic logic [15:0] local_view(input logic [15:0] r);
    return {1'b0, 1'b0, r[ANADV_RF_BIT], 4'h0, r[8:5], ANADV_SELECTOR};
  endfunction

  assign do_write = aw_held_q && w_held_q && !s_axi_bvalid;
  assign local_rd_view = local_view(local_advert_reg_q);
  // Only the low two lanes carry the 16-bit register.
  assign merged = {wstrb_q[1] ? wdata_q[15:8] : local_advert_reg_q[15:8],
                   wstrb_q[0] ? wdata_q[7:0] : local_advert_reg_q[7:0]};

  // Accept address and data independently; ready drops once a beat is held.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (do_write)
        w_held_q <= 1'b0;
    end
  end

  // Ready is registered so the outputs come straight from flops.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end
    else if (clk_en)
    begin
      s_axi_awready <= !aw_held_q && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_held_q && !(s_axi_wvalid && s_axi_wready);
    end
  end

  // Register writes and the write response.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      // Only writable bits are stored; the selector is supplied by the read view, as after any write.
      local_advert_reg_q <= ANADV_LOCAL_RST & ANADV_WR_MASK;
      restart_autoneg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= ANADV_RESP_OKAY;
    end
    else if (clk_en)
    begin
      restart_autoneg <= 1'b0;
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (do_write)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= ANADV_RESP_OKAY;
        case (awaddr_q)
          ANADV_ADDR_LOCAL:
            // Only remote fault and ability bits take the write.
            local_advert_reg_q <= merged & ANADV_WR_MASK;
          ANADV_ADDR_PARTNER:
            // Partner register is read-only; writes are dropped quietly.
            local_advert_reg_q <= local_advert_reg_q;
          ANADV_ADDR_CTRL:
            restart_autoneg <= wstrb_q[0] && wdata_q[ANADV_RESTART_BIT];
          default:
            s_axi_bresp <= ANADV_RESP_SLVERR;
        endcase
      end
    end
  end

  // Active abilities change only on restart, so a write alone never disturbs a live link.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      active_ability <= '{1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
    else if (clk_en && restart_autoneg)
      active_ability <= '{1'b0, local_advert_reg_q[ANADV_RF_BIT], local_advert_reg_q[8],
                          local_advert_reg_q[7], local_advert_reg_q[6], local_advert_reg_q[5]};
  end

  // Partner abilities are captured from the negotiation engine.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      partner_ability_reg_q <= ANADV_PARTNER_RST;
      partner_seen_q <= 1'b0;
    end
    else if (clk_en)
    begin
      if (partner_page_valid)
      begin
        partner_ability_reg_q <= partner_page;
        partner_seen_q <= 1'b1;
      end
      else if (restart_autoneg)
        partner_seen_q <= 1'b0;
    end
  end

  // Read channel: one cycle to arready, data one cycle later.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= ANADV_RESP_OKAY;
    end
    else if (clk_en)
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= ANADV_RESP_OKAY;
        case (s_axi_araddr)
          ANADV_ADDR_LOCAL: s_axi_rdata <= {16'h0000, local_view(local_advert_reg_q)};
          ANADV_ADDR_PARTNER: s_axi_rdata <= {16'h0000, partner_ability_reg_q};
          ANADV_ADDR_CTRL: s_axi_rdata <= {30'h0, partner_seen_q, 1'b0};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= ANADV_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Active set stays put unless a restart happened.
  property p_hold_until_restart;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && !restart_autoneg) |=> $stable(active_ability);
  endproperty
  a_hold_until_restart: assert property (p_hold_until_restart) else $error("active set moved without restart");

  property p_restart_loads;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && restart_autoneg) |=> active_ability.tx100_full_ability == $past(local_advert_reg_q[8]);
  endproperty
  a_restart_loads: assert property (p_restart_loads) else $error("restart did not load abilities");

  property p_write_local;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && do_write && awaddr_q == ANADV_ADDR_LOCAL) |=> local_advert_reg_q == ($past(merged) & ANADV_WR_MASK);
  endproperty
  a_write_local: assert property (p_write_local) else $error("advertisement write lost");

  property p_selector;
    @(posedge aclk) disable iff (!aresetn)
    local_rd_view[4:0] == ANADV_SELECTOR && local_rd_view[15] == 1'b0;
  endproperty
  a_selector: assert property (p_selector) else $error("selector or next page wrong");

  property p_reset_value;
    @(posedge aclk) !aresetn |=> local_rd_view == ANADV_LOCAL_RST && partner_ability_reg_q == ANADV_PARTNER_RST;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset value wrong");

  property p_partner_capture;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && partner_page_valid) |=> partner_ability_reg_q == $past(partner_page);
  endproperty
  a_partner_capture: assert property (p_partner_capture) else $error("partner page not captured");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
    (local_advert_reg_q & ~ANADV_WR_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_rf_sent;
    @(posedge aclk) disable iff (!aresetn)
    (clk_en && restart_autoneg) |=> active_ability.remote_fault_flag == $past(local_advert_reg_q[ANADV_RF_BIT]);
  endproperty
  a_rf_sent: assert property (p_rf_sent) else $error("remote fault not advertised");
endmodule

// *** anadv_partner.sv ***
// Far-side stand-in that hands one base page to the register bank.
// Assumes the bench holds word steady until the next send.
`timescale 1ns/1ps
module anadv_partner
  import anadv_pkg::*;
(
  input wire logic aclk,
  input wire logic send,
  input wire logic [15:0] word,
  output logic page_valid,
  output logic [15:0] page
);
  // The page stands one cycle for each cycle that send is high; otherwise the lines show the inverse so stale data cannot pass.
  always_ff @(posedge aclk)
  begin
    page_valid <= send;
    page <= send ? word : ~word;
  end
endmodule

// *** autoneg_advertisement_regs_tb_top.sv ***
// Self-checking bench for the advertisement register bank.
// Assumes anadv_pkg, anadv_regs and anadv_partner are compiled first.
`timescale 1ns/1ps
module autoneg_advertisement_regs_tb_top;
  import anadv_pkg::*;
  logic aclk = 1'b0;
  logic ce = 1'b1;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h0, araddr = 12'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, send = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [15:0] word = 16'h0, page;
  logic awready, wready, bvalid, arready, rvalid, pv, restart;
  logic [1:0] bresp, rresp;
  anadv_ability_t act;
  logic [33:0] q[$];
  int err_count = 0, cmp_count = 0, cyc = 0, pulses = 0;
  integer seed = 37;
  always #5 aclk = ~aclk;
  anadv_regs uut (.aclk(aclk), .aresetn(aresetn), .clk_en(ce), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .partner_page_valid(pv), .partner_page(page),
    .restart_autoneg(restart), .active_ability(act));
  anadv_partner lp (.aclk(aclk), .send(send), .word(word), .page_valid(pv), .page(page));
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Each task notes its expected answer, then holds every channel until its own handshake edge.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r = ANADV_RESP_OKAY);
    q.push_back({r, 32'h0});
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    q.push_back(e);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    rready <= 1'b0;
  endtask
  // Watches responses in handshake order, counts restart pulses and cuts a hang short.
  always @(posedge aclk)
  begin
    cyc++;
    if (restart) pulses++;
    if (bvalid && bready) chk({bresp, 32'h0}, q.pop_front());
    if (rvalid && rready) chk({rresp, rdata}, q.pop_front());
    if (cyc == 3000)
    begin
      err_count++;
      close_out();
    end
  end
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({28'h0, act}, 34'h00f);
    rd(ANADV_ADDR_LOCAL, 34'h001e1);
    rd(ANADV_ADDR_PARTNER, 34'h0);
    rd(12'h030, {ANADV_RESP_SLVERR, 32'h0});
    // An unmapped write is refused and must not restart negotiation.
    wr(12'h030, 32'h1, ANADV_RESP_SLVERR);
    $display("Test reset values done");
    wr(ANADV_ADDR_LOCAL, 32'hffffffff);
    rd(ANADV_ADDR_LOCAL, 34'h021e1);
    for (int i = 0; i < 8; i++)
    begin
      v = $random(seed);
      wr(ANADV_ADDR_LOCAL, v);
      rd(ANADV_ADDR_LOCAL, {18'h0, v[15:0] & 16'h21e0 | 16'h0001});
    end
    $display("Test write masking done");
    // Reserved bits read as zero, so zero is written back there.
    wr(ANADV_ADDR_LOCAL, 32'h2141);
    chk({28'h0, act}, 34'h00f);
    wr(ANADV_ADDR_CTRL, 32'h1);
    for (int n = 0; n < 10 && pulses == 0; n++) @(posedge aclk);
    repeat (2) @(posedge aclk);
    #1;
    chk(34'(pulses), 34'h1);
    chk({28'h0, act}, 34'h01a);
    $display("Test restart done");
    @(posedge aclk);
    word <= 16'($random(seed));
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    rd(ANADV_ADDR_PARTNER, {18'h0, word});
    wr(ANADV_ADDR_PARTNER, 32'h0);
    rd(ANADV_ADDR_PARTNER, {18'h0, word});
    rd(ANADV_ADDR_CTRL, 34'h2);
    $display("Test partner capture done");
    // A page offered while the clock enable is low must be ignored.
    v = {16'h0, word};
    @(posedge aclk);
    ce <= 1'b0;
    word <= ~word;
    send <= 1'b1;
    @(posedge aclk);
    send <= 1'b0;
    repeat (2) @(posedge aclk);
    ce <= 1'b1;
    rd(ANADV_ADDR_PARTNER, {18'h0, v[15:0]});
    $display("Test clock enable done");
    close_out();
  end
endmodule
